// >>> dv/srv_media_model.sv
// Media engine model: answers each read fetch with 256 words, each verify fetch with none, and a done pulse.
// Assumes the block's clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module srv_media_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Fetch request and fault injection
  input  wire logic        media_start,
  input  wire logic        media_verify,
  input  wire logic [27:0] media_lba,
  input  wire logic [27:0] bad_lba,
  input  wire logic [7:0]  bad_code,
  // Answer
  output logic             media_wvalid,
  output logic [15:0]      media_wdata,
  output logic             media_done,
  output logic [7:0]       media_code
);
  logic        busy_r;
  logic [9:0]  cnt_r;
  logic [27:0] lba_r;
  logic [9:0]  idx;
  assign idx = cnt_r - 10'h020;
  // Odd blocks answer after a two-count wait, even ones after thirty-two; idle data toggles so no stale word passes
  always @(posedge clk) begin
    media_wvalid <= 1'h0;
    media_done   <= 1'h0;
    media_wdata  <= ~media_wdata;
    if (!rst_b) begin
      busy_r      <= 1'h0;
      media_wdata <= 16'h5A5A;
      media_code  <= 8'h00;
    end else if (media_start) begin
      busy_r <= 1'h1;
      lba_r  <= media_lba;
      cnt_r  <= media_lba[0] ? 10'h01E : 10'h000;
    end else if (busy_r) begin
      cnt_r <= cnt_r + 10'h001;
      if (cnt_r == (media_verify ? 10'h020 : 10'h120)) begin
        busy_r     <= 1'h0;
        media_done <= 1'h1;
        media_code <= (lba_r == bad_lba) ? bad_code : 8'h00;
      end else if (cnt_r >= 10'h020 && !media_verify) begin
        media_wvalid <= 1'h1;
        media_wdata  <= {lba_r[7:0], idx[7:0]};
      end
    end
  end
endmodule // srv_media_model
`default_nettype wire

// >>> dv/srv_task_file_checker.sv
// Port checker for the task-file block, bound to its top module.
// Assumes one clock domain and hready looped back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module srv_task_file_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Media and interrupt
  input wire logic        media_start,
  input wire logic        media_verify,
  input wire logic [27:0] media_lba,
  input wire logic        media_done,
  input wire logic [7:0]  media_code,
  input wire logic        intrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Bus phases
  sequence s_rd_taken; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence s_wr_taken; hsel && htrans[1] && hready && hwrite; endsequence
  sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
  sequence s_fatal_vfy; media_done && media_verify && !(media_code inside {8'h00, 8'h01, 8'h18}); endsequence
  // Verify level stays high after the command, so the end is judged per sector done
  sequence s_vfy_done; media_done && media_verify; endsequence
  property p_okay; hresp == 1'h0; endproperty
  property p_rd_wait; s_rd_taken |=> s_one_wait; endproperty
  property p_wr_nowait; s_wr_taken |=> hreadyout; endproperty
  property p_rd_upper; $rose(hreadyout) |-> hrdata[31:16] == 16'h0000; endproperty
  property p_start_pulse; media_start |=> !media_start; endproperty
  property p_lba_hold; !media_start |-> $stable(media_lba); endproperty
  property p_read_irq; media_done && !media_verify |=> intrq; endproperty
  property p_vfy_end; s_vfy_done |-> ##[1:2] (intrq || media_start); endproperty
  property p_vfy_err; s_fatal_vfy |=> !media_start [*3]; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  a_start_pulse: assert property (p_start_pulse) else $error("fetch start too long");
  a_lba_hold: assert property (p_lba_hold) else $error("block moved without fetch");
  a_read_irq: assert property (p_read_irq) else $error("no interrupt after sector");
  a_vfy_end: assert property (p_vfy_end) else $error("verify ended silently");
  a_vfy_err: assert property (p_vfy_err) else $error("verify went on after fault");
endmodule // srv_task_file_checker
bind srv_task_file srv_task_file_checker chk_u (.clk, .rst_b, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .media_start, .media_verify, .media_lba, .media_done, .media_code, .intrq);
`default_nettype wire

// >>> dv/test_storage_read_verify_sense_cmds.sv
// Bench: AHB-Lite master, media model and a queue of expected results.
// Assumes the block's default geometry and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_storage_read_verify_sense_cmds;
  typedef struct {string n; logic [31:0] e;} srv_note_t;
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        hsel = 1'h0;
  logic        hwrite = 1'h0;
  logic        rd_pend = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [27:0] bad_lba = 28'hFFFFFFF;
  logic [7:0]  bad_code = 8'h00;
  wire         hready, hresp, media_start, media_verify, media_wvalid, media_done, intrq;
  wire  [31:0] hrdata;
  wire  [27:0] media_lba;
  wire  [15:0] media_wdata;
  wire  [7:0]  media_code;
  int          err_total = 0, compares = 0, seed = 69980, i, j, k;
  logic [31:0] v;
  logic [27:0] l;
  srv_note_t   nt;
  srv_note_t   nq[$];
  logic [27:0] lq[$];
  logic [31:0] ra[9] = '{32'h08, 32'h0C, 32'h10, 32'h14, 32'h18, 32'h04, 32'h1C, 32'h00, 32'h100};
  logic [7:0]  re[9] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00};
  logic [7:0]  codes[26] = '{8'h00, 8'h01, 8'h18, 8'h11, 8'h10, 8'h14, 8'h09, 8'h1F, 8'h05, 8'h30, 8'h31,
    8'h32, 8'h33, 8'h34, 8'h37, 8'h3E, 8'h35, 8'h36, 8'h22, 8'h03, 8'h3A, 8'h0C, 8'h38, 8'h3B, 8'h3C, 8'h3F};

  srv_task_file dut_u (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .media_start, .media_verify, .media_lba, .media_wvalid,
    .media_wdata, .media_done, .media_code, .intrq);
  srv_media_model mdl_u (.clk, .rst_b, .media_start, .media_verify, .media_lba, .bad_lba, .bad_code,
    .media_wvalid, .media_wdata, .media_done, .media_code);

  always #20 clk = ~clk;

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single transfer; starts and ends just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge clk);
    while (!hready) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hready) @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
    nq.push_back('{n, e});
    bus(1'h0, a, $random(seed));
  endtask
  task automatic setup(input logic [7:0] cnt, input logic [7:0] sn, input logic [7:0] cl, input logic [7:0] ch,
                       input logic [7:0] dh);
    wr(32'h08, {24'h0, cnt});
    wr(32'h0C, {24'h0, sn});
    wr(32'h10, {24'h0, cl});
    wr(32'h14, {24'h0, ch});
    wr(32'h18, {24'h0, dh});
  endtask
  task automatic lba_set(input logic [7:0] cnt, input logic [27:0] a);
    setup(cnt, a[7:0], a[15:8], a[23:16], {4'hE, a[27:24]});
  endtask
  // Bounded wait on the interrupt, then the status read that clears it
  task automatic wait_irq(input logic [31:0] st);
    for (k = 0; k < 20000 && intrq !== 1'h1; k++) @(posedge clk);
    check("interrupt", {31'h0, intrq}, 32'h1);
    rd(32'h1C, st, "status");
  endtask
  task automatic drain(input logic [27:0] b);
    for (k = 0; k < 256; k++) rd(32'h00, {16'h0, b[7:0], k[7:0]}, "sector word");
  endtask
  task automatic sense(input logic [7:0] x);
    wr(32'h1C, 32'h03);
    wait_irq(32'h40);
    rd(32'h04, {24'h0, x}, "sense code");
  endtask
  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Result watcher: each read capture takes the oldest note, each fetch the oldest queued block
  always @(posedge clk) begin
    if (rd_pend && hready) begin
      if (nq.size() == 0) check("stray read", 32'h0, 32'h1);
      else begin
        nt = nq.pop_front();
        check(nt.n, hrdata, nt.e);
      end
    end
    if (hready) rd_pend <= hsel && htrans[1] && !hwrite;
    if (media_start) begin
      if (lq.size() == 0) check("stray fetch", 32'h0, 32'h1);
      else check("fetch block", {4'h0, media_lba}, {4'h0, lq.pop_front()});
    end
  end

  // Watchdog sized well above the expected run of some 20000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    // Reset values, unmapped place, then random read-back
    for (i = 0; i < 9; i++) rd(ra[i], {24'h0, re[i]}, "reset value");
    for (i = 0; i < 5; i++) begin
      v = $random(seed);
      wr(ra[i], v);
      rd(ra[i], {24'h0, v[7:0]}, "read back");
    end
    wr(32'h04, 32'hFF);
    rd(32'h04, 32'h00, "error after feature");
    $display("test registers done");
    // Two-sector CHS read under both read opcodes
    for (i = 0; i < 2; i++) begin
      setup(8'h02, 8'h03, 8'h01, 8'h00, 8'hA2);
      lq.push_back(28'h0000470);
      lq.push_back(28'h0000471);
      wr(32'h1C, 32'h20 + i);
      for (j = 0; j < 2; j++) begin
        wait_irq(32'h48);
        drain(28'(28'h470 + j));
      end
      rd(32'h0C, 32'h04, "last sector");
      rd(32'h1C, 32'h40, "read end");
    end
    $display("test read done");
    // Full 256-sector verify with a refused write while busy
    lba_set(8'h00, 28'h0001000);
    for (i = 0; i < 256; i++) lq.push_back(28'(28'h1000 + i));
    wr(32'h1C, 32'h40);
    rd(32'h1C, 32'h80, "verify busy");
    wr(32'h0C, 32'h55);
    wait_irq(32'h40);
    rd(32'h0C, 32'hFF, "verify last");
    rd(32'h10, 32'h10, "verify last cyl");
    // Verify stopped by a fault on its third sector
    lba_set(8'h05, 28'h0002001);
    bad_lba <= 28'h0002003;
    bad_code <= 8'h11;
    for (i = 1; i < 4; i++) lq.push_back(28'(28'h2000 + i));
    wr(32'h1C, 32'h41);
    wait_irq(32'h41);
    rd(32'h0C, 32'h03, "verify fail sector");
    rd(32'h08, 32'h03, "verify left");
    sense(8'h11);
    sense(8'h00);
    $display("test verify done");
    // Twenty-six extended codes through a one-sector read
    for (i = 0; i < 26; i++) begin
      l = 28'(28'h3000 + i);
      lba_set(8'h01, l);
      bad_lba <= l;
      bad_code <= codes[i];
      lq.push_back(l);
      wr(32'h1C, 32'h21);
      if (codes[i] inside {8'h00, 8'h01, 8'h18}) begin
        wait_irq(32'h48);
        drain(l);
      end else begin
        wait_irq(32'h41);
        rd(32'h0C, {24'h0, l[7:0]}, "fail sector");
      end
      sense(codes[i]);
    end
    $display("test codes done");
    // Mid-run reset brings the task registers back to their defaults
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd(32'h0C, 32'h01, "sector after reset");
    rd(32'h1C, 32'h40, "status after reset");
    rd(32'h04, 32'h00, "error after reset");
    $display("test reset done");
    // Refused addresses, an unknown opcode and recalibrate never reach the media
    setup(8'h01, 8'h00, 8'h00, 8'h00, 8'hA0);
    wr(32'h1C, 32'h20);
    wait_irq(32'h41);
    sense(8'h21);
    lba_set(8'h01, 28'hFFFFFFF);
    wr(32'h1C, 32'h20);
    wait_irq(32'h41);
    sense(8'h2F);
    wr(32'h1C, 32'hA5);
    wait_irq(32'h41);
    sense(8'h20);
    for (i = 0; i < 4; i++) begin
      wr(32'h1C, 32'h10 + 5 * i);
      wait_irq(32'h40);
      sense(8'h00);
    end
    $display("test refusals done");
    repeat (4) @(posedge clk);
    check("notes left", nq.size() + lq.size(), 32'h0);
    conclude();
  end
endmodule // test_storage_read_verify_sense_cmds
`default_nettype wire

// >>> hdl/srv_defs.vh
// Constants for the task-file command block: register word indexes,
// status bit positions, error bit masks, opcodes, extended codes, reset values.
// Assumes one includer; definitions only.
`ifndef SRV_DEFS_VH
`define SRV_DEFS_VH

// Register word indexes (byte address = 4 * index)
`define SRV_IDX_DATA      6'h00
`define SRV_IDX_ERR_FEAT  6'h01
`define SRV_IDX_SEC_CNT   6'h02
`define SRV_IDX_SEC_NUM   6'h03
`define SRV_IDX_CYL_LOW   6'h04
`define SRV_IDX_CYL_HIGH  6'h05
`define SRV_IDX_DRV_HEAD  6'h06
`define SRV_IDX_CMD_STAT  6'h07

// Status register bit positions
`define SRV_ST_BSY        7
`define SRV_ST_RDY        6
`define SRV_ST_DRQ        3
`define SRV_ST_ERR        0

// Drive/head register fields
`define SRV_DH_LBA        6
`define SRV_DH_HEAD_HI    3

// Error register bits
`define SRV_ER_UNC        8'h40
`define SRV_ER_IDNF       8'h10
`define SRV_ER_ABRT       8'h04

// Opcodes
`define SRV_OP_READ_A     8'h20
`define SRV_OP_READ_B     8'h21
`define SRV_OP_VERIFY_A   8'h40
`define SRV_OP_VERIFY_B   8'h41
`define SRV_OP_RECAL_HI   4'h1
`define SRV_OP_SENSE      8'h03

// Extended error codes
`define SRV_EX_NONE       8'h00
`define SRV_EX_SELFTEST   8'h01
`define SRV_EX_MISC       8'h09
`define SRV_EX_BAD_CMD    8'h20
`define SRV_EX_BAD_ADDR   8'h21
`define SRV_EX_OVERFLOW   8'h2F
`define SRV_EX_XFER_ABRT  8'h1F
`define SRV_EX_UNC_ECC    8'h11
`define SRV_EX_COR_ECC    8'h18
`define SRV_EX_IDNF_A     8'h10
`define SRV_EX_IDNF_B     8'h14

// Sector geometry and reset values
`define SRV_LAST_WORD     8'hFF
`define SRV_FULL_COUNT    9'h100
`define SRV_ONE_SECTOR    9'h001
`define SRV_RST_SEC_CNT   8'h01
`define SRV_RST_SEC_NUM   8'h01
`define SRV_RST_ZERO8     8'h00

`endif

// >>> hdl/srv_task_file.v
// Task-file command interpreter: sector read, read-verify, recalibrate
// and request-sense, with task registers on an AHB-Lite slave port.
// Assumes one clock, a single AHB master and a media engine on the same
// clock that answers each media_start with media_wvalid words and one
// media_done carrying an extended code.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "srv_defs.vh"

module srv_task_file #(
  parameter [15:0] CYLS  = 16'h0400,
  parameter [7:0]  HEADS = 8'h10,
  parameter [7:0]  SPT   = 8'h3F
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // Media engine
  output wire        media_start,
  output wire        media_verify,
  output wire [27:0] media_lba,
  input  wire        media_wvalid,
  input  wire [15:0] media_wdata,
  input  wire        media_done,
  input  wire [7:0]  media_code,
  // Host interrupt request
  output wire        intrq
);

  // One-hot states
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_CHECK = 4'b0010;
  localparam [3:0] ST_FETCH = 4'b0100;
  localparam [3:0] ST_XFER  = 4'b1000;

  reg  [3:0]  state_r;
  reg  [7:0]  sector_count_r;
  reg  [7:0]  sector_number_r;
  reg  [7:0]  cylinder_low_r;
  reg  [7:0]  cylinder_high_r;
  reg  [7:0]  drive_head_r;
  reg  [7:0]  err_r;
  reg  [7:0]  ext_r;
  reg         bsy_r;
  reg         drq_r;
  reg         errbit_r;
  reg         intrq_r;
  reg         verify_r;
  reg  [8:0]  rem_r;
  reg  [7:0]  wptr_r;
  reg  [7:0]  rptr_r;
  reg         media_start_r;
  reg  [27:0] media_lba_r;
  reg  [31:0] hrdata_r;
  reg         wr_pend_r;
  reg  [5:0]  wr_idx_r;
  reg         rd_ph_r;
  reg  [5:0]  rd_idx_r;
  reg  [15:0] sec_buf [0:255];

  wire        addr_ph;
  wire        wr_take;
  wire        rd_take;
  wire        pop;
  wire        stat_rd;
  wire [7:0]  wr_byte;
  wire [7:0]  range_code;
  wire [31:0] next_addr;
  wire [8:0]  rem_dec;

  // Address phase accepted only when the bus is ready
  assign addr_ph   = hsel & htrans[1] & hready;
  assign wr_take   = wr_pend_r;
  // Reads take one wait state so that data comes from a flip-flop
  assign rd_take   = rd_ph_r;
  assign hreadyout = ~rd_ph_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign wr_byte   = hwdata[7:0];
  assign pop       = rd_take & (rd_idx_r == `SRV_IDX_DATA) & drq_r;
  assign stat_rd   = rd_take & (rd_idx_r == `SRV_IDX_CMD_STAT);
  assign rem_dec   = rem_r - `SRV_ONE_SECTOR;

  assign media_start  = media_start_r;
  assign media_verify = verify_r;
  assign media_lba    = media_lba_r;
  assign intrq        = intrq_r;

  // Linear block number of the addressed sector
  function [27:0] to_lba;
    input [7:0] dh;
    input [7:0] ch;
    input [7:0] cl;
    input [7:0] sn;
    reg   [31:0] t;
    begin
      t = 32'h0;
      if (dh[`SRV_DH_LBA]) begin
        t = {4'h0, dh[`SRV_DH_HEAD_HI:0], ch, cl, sn};
      end else begin
        t = (({16'h0, ch, cl} * {24'h0, HEADS}) + {28'h0, dh[`SRV_DH_HEAD_HI:0]}) * {24'h0, SPT}
            + {24'h0, sn} - 32'h1;
      end
      to_lba = t[27:0];
    end
  endfunction

  // Address of the following sector as {drive_head, cyl_high, cyl_low, sector}
  function [31:0] addr_inc;
    input [7:0] dh;
    input [7:0] ch;
    input [7:0] cl;
    input [7:0] sn;
    reg   [27:0] l;
    reg   [15:0] c;
    reg   [3:0]  h;
    begin
      l = {dh[`SRV_DH_HEAD_HI:0], ch, cl, sn} + 28'h1;
      c = {ch, cl};
      h = dh[`SRV_DH_HEAD_HI:0];
      if (dh[`SRV_DH_LBA]) begin
        addr_inc = {dh[7:4], l};
      end else if (sn >= SPT) begin
        if ({4'h0, h} >= HEADS - 8'h1) begin
          c = c + 16'h1;
          addr_inc = {dh[7:4], 4'h0, c, `SRV_RST_SEC_NUM};
        end else begin
          h = h + 4'h1;
          addr_inc = {dh[7:4], h, c, `SRV_RST_SEC_NUM};
        end
      end else begin
        addr_inc = {dh, ch, cl, sn + 8'h1};
      end
    end
  endfunction

  // Extended code for an address outside the card
  function [7:0] addr_check;
    input [7:0] dh;
    input [7:0] ch;
    input [7:0] cl;
    input [7:0] sn;
    reg   [31:0] cap;
    begin
      cap = {16'h0, CYLS} * {24'h0, HEADS} * {24'h0, SPT};
      if (dh[`SRV_DH_LBA]) begin
        if ({4'h0, dh[`SRV_DH_HEAD_HI:0], ch, cl, sn} >= cap)
          addr_check = `SRV_EX_OVERFLOW;
        else
          addr_check = `SRV_EX_NONE;
      end else if (({4'h0, dh[`SRV_DH_HEAD_HI:0]} >= HEADS) || (sn == 8'h00) || (sn > SPT)) begin
        addr_check = `SRV_EX_BAD_ADDR;
      end else if ({ch, cl} >= CYLS) begin
        addr_check = `SRV_EX_OVERFLOW;
      end else begin
        addr_check = `SRV_EX_NONE;
      end
    end
  endfunction

  // Whether a media code ends the command; corrected ECC does not
  function is_fatal;
    input [7:0] code;
    begin
      // Corrected ECC lets the transfer go on
      is_fatal = (code != `SRV_EX_NONE) && (code != `SRV_EX_SELFTEST) && (code != `SRV_EX_COR_ECC);
    end
  endfunction

  // Error register bits that go with an extended code
  function [7:0] err_bits;
    input [7:0] code;
    begin
      case (code)
        `SRV_EX_UNC_ECC:  err_bits = `SRV_ER_UNC;
        `SRV_EX_IDNF_A,
        `SRV_EX_IDNF_B,
        `SRV_EX_BAD_ADDR,
        `SRV_EX_OVERFLOW: err_bits = `SRV_ER_IDNF;
        default:          err_bits = `SRV_ER_ABRT;
      endcase
    end
  endfunction

  assign range_code = addr_check(drive_head_r, cylinder_high_r, cylinder_low_r, sector_number_r);
  assign next_addr  = addr_inc(drive_head_r, cylinder_high_r, cylinder_low_r, sector_number_r);

  // Bus phase tracking: writes commit in their data phase
  always @(posedge clk) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 6'h00;
      rd_ph_r   <= 1'b0;
      rd_idx_r  <= 6'h00;
    end else begin
      wr_pend_r <= addr_ph & hwrite;
      rd_ph_r   <= addr_ph & ~hwrite;
      if (addr_ph) begin
        wr_idx_r <= (haddr[31:8] == 24'h0) ? haddr[7:2] : 6'h3F;
        rd_idx_r <= (haddr[31:8] == 24'h0) ? haddr[7:2] : 6'h3F;
      end
    end
  end

  // Read data mux; unmapped words read as zero
  always @(posedge clk) begin
    if (!rst_b) begin
      hrdata_r <= 32'h0;
    end else if (rd_take) begin
      case (rd_idx_r)
        `SRV_IDX_DATA:     hrdata_r <= drq_r ? {16'h0, sec_buf[rptr_r]} : 32'h0;
        `SRV_IDX_ERR_FEAT: hrdata_r <= {24'h0, err_r};
        `SRV_IDX_SEC_CNT:  hrdata_r <= {24'h0, sector_count_r};
        `SRV_IDX_SEC_NUM:  hrdata_r <= {24'h0, sector_number_r};
        `SRV_IDX_CYL_LOW:  hrdata_r <= {24'h0, cylinder_low_r};
        `SRV_IDX_CYL_HIGH: hrdata_r <= {24'h0, cylinder_high_r};
        `SRV_IDX_DRV_HEAD: hrdata_r <= {24'h0, drive_head_r};
        `SRV_IDX_CMD_STAT: hrdata_r <= {24'h0, bsy_r, ~bsy_r, 2'b00, drq_r, 2'b00, errbit_r};
        default:           hrdata_r <= 32'h0;
      endcase
    end
  end

  // Sector buffer fill; contents stay until the next fetch
  always @(posedge clk) begin
    if (state_r == ST_FETCH && media_wvalid) begin
      sec_buf[wptr_r] <= media_wdata;
    end
  end

  // Command sequencer and task registers
  always @(posedge clk) begin
    if (!rst_b) begin
      state_r         <= ST_IDLE;
      sector_count_r  <= `SRV_RST_SEC_CNT;
      sector_number_r <= `SRV_RST_SEC_NUM;
      cylinder_low_r  <= `SRV_RST_ZERO8;
      cylinder_high_r <= `SRV_RST_ZERO8;
      drive_head_r    <= `SRV_RST_ZERO8;
      err_r           <= `SRV_RST_ZERO8;
      ext_r           <= `SRV_EX_NONE;
      bsy_r           <= 1'b0;
      drq_r           <= 1'b0;
      errbit_r        <= 1'b0;
      intrq_r         <= 1'b0;
      verify_r        <= 1'b0;
      rem_r           <= 9'h000;
      wptr_r          <= 8'h00;
      rptr_r          <= 8'h00;
      media_start_r   <= 1'b0;
      media_lba_r     <= 28'h0;
    end else begin
      media_start_r <= 1'b0;
      // Reading status acknowledges the interrupt; a new event wins below
      if (stat_rd)
        intrq_r <= 1'b0;
      if (state_r == ST_FETCH && media_wvalid)
        wptr_r <= wptr_r + 8'h1;
      case (state_r)
        ST_IDLE: begin
          // No writes or commands while busy or draining
          if (wr_take && !drq_r) begin
            case (wr_idx_r)
              `SRV_IDX_SEC_CNT:  sector_count_r  <= wr_byte;
              `SRV_IDX_SEC_NUM:  sector_number_r <= wr_byte;
              `SRV_IDX_CYL_LOW:  cylinder_low_r  <= wr_byte;
              `SRV_IDX_CYL_HIGH: cylinder_high_r <= wr_byte;
              `SRV_IDX_DRV_HEAD: drive_head_r    <= wr_byte;
              `SRV_IDX_CMD_STAT: begin
                intrq_r <= 1'b0;
                // Two read opcodes, two verify opcodes
                if (wr_byte == `SRV_OP_READ_A || wr_byte == `SRV_OP_READ_B ||
                    wr_byte == `SRV_OP_VERIFY_A || wr_byte == `SRV_OP_VERIFY_B) begin
                  verify_r <= (wr_byte == `SRV_OP_VERIFY_A) || (wr_byte == `SRV_OP_VERIFY_B);
                  rem_r    <= (sector_count_r == 8'h00) ? `SRV_FULL_COUNT : {1'b0, sector_count_r};
                  bsy_r    <= 1'b1;
                  errbit_r <= 1'b0;
                  err_r    <= `SRV_RST_ZERO8;
                  ext_r    <= `SRV_EX_NONE;
                  state_r  <= ST_CHECK;
                end else if (wr_byte[7:4] == `SRV_OP_RECAL_HI) begin
                  ext_r    <= `SRV_EX_NONE;
                  err_r    <= `SRV_RST_ZERO8;
                  errbit_r <= 1'b0;
                  intrq_r  <= 1'b1;
                end else if (wr_byte == `SRV_OP_SENSE) begin
                  err_r    <= ext_r;
                  ext_r    <= `SRV_EX_NONE;
                  errbit_r <= 1'b0;
                  intrq_r  <= 1'b1;
                end else begin
                  ext_r    <= `SRV_EX_BAD_CMD;
                  err_r    <= `SRV_ER_ABRT;
                  errbit_r <= 1'b1;
                  intrq_r  <= 1'b1;
                end
              end
              default: ;
            endcase
          end
        end
        ST_CHECK: begin
          if (range_code != `SRV_EX_NONE) begin
            ext_r    <= range_code;
            err_r    <= err_bits(range_code);
            errbit_r <= 1'b1;
            bsy_r    <= 1'b0;
            intrq_r  <= 1'b1;
            state_r  <= ST_IDLE;
          end else begin
            media_lba_r   <= to_lba(drive_head_r, cylinder_high_r, cylinder_low_r, sector_number_r);
            media_start_r <= 1'b1;
            wptr_r        <= 8'h00;
            state_r       <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (media_done) begin
            if (!is_fatal(media_code))
              ext_r <= media_code;
            if (is_fatal(media_code)) begin
              // Stop here; count holds sectors left
              ext_r    <= media_code;
              err_r    <= err_bits(media_code);
              errbit_r <= 1'b1;
              bsy_r    <= 1'b0;
              intrq_r  <= 1'b1;
              state_r  <= ST_IDLE;
            end else if (!verify_r) begin
              // Buffer full: DRQ, clear BSY, interrupt
              drq_r   <= 1'b1;
              bsy_r   <= 1'b0;
              intrq_r <= 1'b1;
              rptr_r  <= 8'h00;
              state_r <= ST_XFER;
            end else begin
              sector_count_r <= rem_dec[7:0];
              if (rem_r == `SRV_ONE_SECTOR) begin
                bsy_r   <= 1'b0;
                intrq_r <= 1'b1;
                state_r <= ST_IDLE;
              end else begin
                rem_r           <= rem_dec;
                {drive_head_r, cylinder_high_r, cylinder_low_r, sector_number_r} <= next_addr;
                state_r         <= ST_CHECK;
              end
            end
          end
        end
        ST_XFER: begin
          if (pop) begin
            rptr_r <= rptr_r + 8'h1;
            if (rptr_r == `SRV_LAST_WORD) begin
              drq_r          <= 1'b0;
              sector_count_r <= rem_dec[7:0];
              if (rem_r == `SRV_ONE_SECTOR) begin
                // Last sector address left in place
                state_r <= ST_IDLE;
              end else begin
                // Set BSY before the next fill
                rem_r   <= rem_dec;
                bsy_r   <= 1'b1;
                {drive_head_r, cylinder_high_r, cylinder_low_r, sector_number_r} <= next_addr;
                state_r <= ST_CHECK;
              end
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // srv_task_file

`default_nettype wire
